// ---- hdl/wave_params.svh ----
// Constants for the 8-bit waveform timer: offsets, fields, masks, resets, interrupt bits.
// Assumes inclusion by the top module only.
// Contract
// - Nonzero action field routes that channel's compare output onto its pin, except action 1 in PWM modes unless on A with high mode bit.
// - Non-PWM channel A: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM A: 1 toggles only with high mode bit; 2/3 match and BOTTOM.
// - Phase correct A: 2 clear up, set down; 3 inverse; 1 toggle if high.
// - Non-PWM channel B: 0 off, 1 toggle, 2 clear, 3 set on match.
// - Fast PWM B: 1 reserved; 2 clear match set BOTTOM; 3 inverse.
// - Phase correct B: 1 reserved; 2 clear up, set down; 3 reverse.
// - Fast PWM, compare equals TOP, action high bit: act at BOTTOM instead.
// - Phase correct, compare equals TOP, action high bit: act at TOP instead.
// - Control bits 3 and 2 always read zero.
// - Low mode bits with high mode bit select sequence, TOP and waveform.
// - Modes 0,1,3 TOP 0xFF; 2,5,7 TOP compare A; 4,6 reserved.
// - Compare update and overflow flag timing follow the mode table.
// - High mode bit is bit 3 of the companion control register.
// - In phase correct modes overflow sets when direction turns at zero.
`ifndef WAVE_PARAMS_SVH
`define WAVE_PARAMS_SVH
`define OFS_CTRL_A 8'hB0
`define OFS_CTRL_B 8'hB1
`define OFS_COUNT 8'hB2
`define OFS_CMP_A 8'hB3
`define OFS_CMP_B 8'hB4
`define OFS_IRQ_STATUS 8'hB8
`define OFS_IRQ_MASK 8'hB9
`define POS_ACT_A 6
`define POS_ACT_B 4
`define POS_MODE_HIGH 3
`define CTRL_A_WMASK 8'hF3
`define CTRL_B_WMASK 8'h08
`define RST_BYTE 8'h00
`define VAL_MAX 8'hFF
`define VAL_BOTTOM 8'h00
`define IRQ_OVF 0
`define IRQ_CMP_A 1
`define IRQ_CMP_B 2
`define IRQ_WMASK 8'h07
`endif

// ---- hdl/wave_pkg.sv ----
// Types for the 8-bit waveform timer.
// Assumes wave_params.svh sits beside it.
package wave_pkg;
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0, MODE_PC_FF = 3'h1, MODE_CTC = 3'h2, MODE_FAST_FF = 3'h3,
        MODE_RES4 = 3'h4, MODE_PC_CMP = 3'h5, MODE_RES6 = 3'h6, MODE_FAST_CMP = 3'h7
    } wave_mode_type;
    typedef enum logic [1:0] {
        ACT_OFF = 2'h0, ACT_TOGGLE = 2'h1, ACT_CLEAR = 2'h2, ACT_SET = 2'h3
    } action_type;
    typedef struct packed {
        logic [7:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } bus_req_type;
    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
        logic readdatavalid;
    } bus_rsp_type;
    typedef struct packed {
        logic [1:0] out;
        logic [1:0] en;
    } compare_pins_type;
endpackage

// ---- hdl/compare_channel.sv ----
// One compare output channel: decides the next pin level from mode and action.
// Assumes counter, direction and TOP are supplied by the timer core.
`timescale 1ns/1ps
module compare_channel
    import wave_pkg::*;
#(
    parameter bit IS_A = 1'b1
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [1:0] action,
    input wire wave_mode_type mode,
    input wire logic [7:0] count,
    input wire logic counting_down,
    input wire logic tick_top,
    input wire logic [7:0] top_value,
    input wire logic [7:0] compare,
    output logic pin_level
);
    typedef struct packed {
        logic level;
    } chan_state_type;
    chan_state_type state, next_state;
    logic is_fast, is_pc, match, special;
    always_comb begin
        next_state = state;
        is_fast = (mode == MODE_FAST_FF) || (mode == MODE_FAST_CMP);
        is_pc = (mode == MODE_PC_FF) || (mode == MODE_PC_CMP);
        match = (count == compare);
        special = (compare == top_value) && action[1];
        if (!is_fast && !is_pc) begin
            if (match) begin
                unique case (action)
                    ACT_TOGGLE: next_state.level = ~state.level;
                    ACT_CLEAR: next_state.level = 1'b0;
                    ACT_SET: next_state.level = 1'b1;
                    ACT_OFF: next_state.level = state.level;
                endcase
            end
        end else if (action == ACT_TOGGLE) begin
            // Toggle only on A with high mode bit; B treats it as reserved
            if (IS_A && mode[2] && match) begin
                next_state.level = ~state.level;
            end
        end else if (action[1] && is_fast) begin
            // Level turns as the count wraps, so the pin is already set (action 2) or cleared (action 3) during BOTTOM
            if (tick_top) begin
                next_state.level = ~action[0];
            end else if (match && !special) begin
                next_state.level = action[0];
            end
        end else if (action[1] && is_pc) begin
            if (special) begin
                // Down-counting level at TOP, so a compare at TOP gives full duty with action 2 and zero duty with action 3
                if (tick_top) begin
                    next_state.level = ~action[0];
                end
            end else if (match) begin
                next_state.level = counting_down ? ~action[0] : action[0];
            end
        end
    end
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end
    assign pin_level = state.level;
endmodule // compare_channel

// ---- hdl/wave_timer.sv ----
// 8-bit waveform timer with control, compare and interrupt registers.
// Assumes an Avalon-MM master on mclk; pin direction is handled by the port logic outside.
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/1ps
`include "wave_params.svh"
module wave_timer
    import wave_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire bus_req_type bus_req,
    output bus_rsp_type bus_rsp,
    output compare_pins_type pins,
    output logic irq
);
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic mode_high;
        logic [7:0] count;
        logic down;
        logic [7:0] cmp_a_buf;
        logic [7:0] cmp_b_buf;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [2:0] status;
        logic [2:0] mask;
        logic busy;
        bus_rsp_type rsp;
        compare_pins_type pins;
        logic irq;
    } timer_state_type;
    timer_state_type state, next_state;
    wave_mode_type mode;
    logic [7:0] top_value;
    logic [1:0] level;
    logic is_fast, is_pc, at_top, at_bottom, ovf_event;
    logic [2:0] events;
    logic [2:0] clr;
    logic wr, rd;
    logic [7:0] wdata;
    logic [7:0] rdata;

    function automatic logic [7:0] field_byte(input logic [31:0] d);
        field_byte = d[7:0];
    endfunction

    // PWM modes leave action 1 disconnected unless toggling is allowed
    function automatic logic routed(input logic [1:0] act, input logic pwm, input logic tog_ok);
        routed = (act != ACT_OFF) && !(pwm && act == ACT_TOGGLE && !tog_ok);
    endfunction

    assign mode = wave_mode_type'({state.mode_high, state.ctrl_a[1:0]});
    assign is_fast = (mode == MODE_FAST_FF) || (mode == MODE_FAST_CMP);
    assign is_pc = (mode == MODE_PC_FF) || (mode == MODE_PC_CMP);
    // Modes 2,5,7 take TOP from compare A; reserved codes run as full range
    assign top_value = (mode == MODE_CTC || mode == MODE_PC_CMP || mode == MODE_FAST_CMP)
        ? state.cmp_a : `VAL_MAX;
    assign at_top = (state.count == top_value);
    assign at_bottom = (state.count == `VAL_BOTTOM);
    // Write lands on the edge the master sees waitrequest low
    assign wr = bus_req.write && state.busy && bus_req.byteenable[0];
    assign rd = bus_req.read && !state.busy;
    assign wdata = field_byte(bus_req.writedata);

    always_comb begin
        // Overflow moment per mode
        unique case (mode)
            MODE_PC_FF, MODE_PC_CMP: ovf_event = at_bottom && state.down;
            MODE_FAST_CMP: ovf_event = at_top;
            default: ovf_event = (state.count == `VAL_MAX);
        endcase
        events = '0;
        events[`IRQ_OVF] = ovf_event;
        events[`IRQ_CMP_A] = (state.count == state.cmp_a);
        events[`IRQ_CMP_B] = (state.count == state.cmp_b);
        clr = '0;
        if (wr && bus_req.address == `OFS_IRQ_STATUS) begin
            clr = wdata[2:0] & 3'(`IRQ_WMASK);
        end
        rdata = '0;
        unique case (bus_req.address)
            `OFS_CTRL_A: rdata = state.ctrl_a & `CTRL_A_WMASK;
            `OFS_CTRL_B: rdata = {4'h0, state.mode_high, 3'h0};
            `OFS_COUNT: rdata = state.count;
            `OFS_CMP_A: rdata = state.cmp_a_buf;
            `OFS_CMP_B: rdata = state.cmp_b_buf;
            `OFS_IRQ_STATUS: rdata = {5'h00, state.status};
            `OFS_IRQ_MASK: rdata = {5'h00, state.mask};
            default: rdata = '0;
        endcase
    end

    always_comb begin
        next_state = state;
        // Single wait state: a read is taken on the edge where busy is low, a write on the edge where busy is high
        next_state.busy = (bus_req.read || bus_req.write) && !state.busy;
        next_state.rsp.waitrequest = !((bus_req.read || bus_req.write) && !state.busy);
        next_state.rsp.readdatavalid = 1'b0;
        if (rd) begin
            next_state.rsp.readdata = {24'h000000, rdata};
        end
        // Counting sequence
        if (is_pc) begin
            if (!state.down) begin
                if (at_top) begin
                    next_state.down = 1'b1;
                    next_state.count = state.count - 8'h01;
                end else begin
                    next_state.count = state.count + 8'h01;
                end
            end else if (at_bottom) begin
                next_state.down = 1'b0;
                next_state.count = state.count + 8'h01;
            end else begin
                next_state.count = state.count - 8'h01;
            end
        end else begin
            next_state.down = 1'b0;
            next_state.count = at_top ? `VAL_BOTTOM : state.count + 8'h01;
        end
        // Compare buffers reach the comparators per mode
        if ((is_pc && at_top) || (is_fast && at_bottom) || (!is_pc && !is_fast)) begin
            next_state.cmp_a = state.cmp_a_buf;
            next_state.cmp_b = state.cmp_b_buf;
        end
        // Set wins over a simultaneous write-one clear
        next_state.status = (state.status & ~clr) | events;
        if (wr) begin
            unique case (bus_req.address)
                `OFS_CTRL_A: next_state.ctrl_a = wdata & `CTRL_A_WMASK;
                `OFS_CTRL_B: next_state.mode_high = wdata[`POS_MODE_HIGH];
                `OFS_COUNT: next_state.count = wdata;
                `OFS_CMP_A: next_state.cmp_a_buf = wdata;
                `OFS_CMP_B: next_state.cmp_b_buf = wdata;
                `OFS_IRQ_MASK: next_state.mask = wdata[2:0];
                default: next_state.mask = next_state.mask;
            endcase
        end
        next_state.irq = |(next_state.status & next_state.mask);
        next_state.pins.out = level;
        next_state.pins.en[1] = routed(state.ctrl_a[`POS_ACT_A +: 2], is_fast || is_pc,
            state.mode_high);
        next_state.pins.en[0] = routed(state.ctrl_a[`POS_ACT_B +: 2], is_fast || is_pc,
            1'b0);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.rsp.waitrequest <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    compare_channel #(.IS_A(1'b1)) chan_a (
        .mclk(mclk), .rst_n(rst_n), .action(state.ctrl_a[`POS_ACT_A +: 2]), .mode(mode),
        .count(state.count), .counting_down(state.down), .tick_top(at_top),
        .top_value(top_value), .compare(state.cmp_a), .pin_level(level[1])
    );
    compare_channel #(.IS_A(1'b0)) chan_b (
        .mclk(mclk), .rst_n(rst_n), .action(state.ctrl_a[`POS_ACT_B +: 2]), .mode(mode),
        .count(state.count), .counting_down(state.down), .tick_top(at_top),
        .top_value(top_value), .compare(state.cmp_b), .pin_level(level[0])
    );

    assign bus_rsp = state.rsp;
    assign pins = state.pins;
    assign irq = state.irq;
endmodule // wave_timer

// ---- sim/pin_load.sv ----
// Load circuitry on the two compare pins.
// Assumes pull-downs on both pins and a bench-set direction bit.
`timescale 1ns/1ps
module pin_load
    import wave_pkg::*;
(
    input wire compare_pins_type pins,
    input wire logic [1:0] dir,
    output logic [1:0] level
);
    // Undriven pin falls to its pull-down
    assign level = pins.en & dir & pins.out;
endmodule // pin_load

// ---- sim/wave_timer_asserts.sv ----
// Checker on the ports of wave_timer.
// Assumes a bus master that holds each request until accepted.
`timescale 1ns/1ps
module wave_timer_asserts
    import wave_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire bus_req_type bus_req,
    input wire bus_rsp_type bus_rsp,
    input wire compare_pins_type pins,
    input wire logic irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [7:0] ctrl;
    logic seen;
    logic hi_sh;
    logic [2:0] mask_sh;
    wire logic req = bus_req.read | bus_req.write;
    wire logic acc = req & !bus_rsp.waitrequest;
    wire logic wr_a = acc & bus_req.write & bus_req.address == 8'hB0 & bus_req.byteenable[0];
    wire logic wr_b = acc & bus_req.write & bus_req.address == 8'hB1 & bus_req.byteenable[0];
    wire logic wr_m = acc & bus_req.write & bus_req.address == 8'hB9 & bus_req.byteenable[0];
    // Odd mode codes are the PWM ones; action 1 there needs the high mode bit on A
    wire logic [1:0] route = {(|ctrl[7:6]) & !(ctrl[0] & ctrl[7:6] == 2'b01 & !hi_sh),
        (|ctrl[5:4]) & !(ctrl[0] & ctrl[5:4] == 2'b01)};
    // Shadows of control and mask, so pin routing and irq can be judged
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= 8'h00;
            seen <= 1'b0;
            hi_sh <= 1'b0;
            mask_sh <= 3'h0;
        end else begin
            if (wr_a) begin
                ctrl <= bus_req.writedata[7:0];
                seen <= 1'b1;
            end
            if (wr_b) begin
                hi_sh <= bus_req.writedata[3];
            end
            if (wr_m) begin
                mask_sh <= bus_req.writedata[2:0];
            end
        end
    end
    sequence s_wait;
        req && bus_rsp.waitrequest;
    endsequence
    sequence s_rd_ctrl;
        acc && bus_req.read && bus_req.address == 8'hB0;
    endsequence
    a_answer_bound: assert property (s_wait |-> ##[1:2] !bus_rsp.waitrequest)
        else $error("request not answered");
    a_accept_once: assert property (!bus_rsp.waitrequest |=> bus_rsp.waitrequest)
        else $error("waitrequest low too long");
    a_idle_wait: assert property (!req |=> bus_rsp.waitrequest)
        else $error("accept without request");
    a_reserved_zero: assert property (s_rd_ctrl |-> bus_rsp.readdata[3:2] == 2'b00)
        else $error("reserved control bits not zero");
    a_ctrl_readback: assert property (s_rd_ctrl and seen |-> bus_rsp.readdata[7:0] == (ctrl & 8'hF3))
        else $error("control readback wrong");
    a_route_pins: assert property (wr_a |=> ##1 pins.en == route)
        else $error("pin routing wrong");
    a_irq_masked: assert property (mask_sh == 3'h0 |-> !irq)
        else $error("irq high with all sources masked");
    a_reset_off: assert property (!seen |-> pins.en == 2'b00)
        else $error("pin routed after reset");
    a_unmapped_zero: assert property (acc && bus_req.read && bus_req.address == 8'hB5
        |-> bus_rsp.readdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule // wave_timer_asserts
bind wave_timer wave_timer_asserts wave_timer_asserts_i (.mclk(mclk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .pins(pins), .irq(irq));

// ---- sim/timer8_waveform_output_control_test.sv ----
// Bench for wave_timer: bus tasks, waveform duty model, pin load.
// Assumes only the run's cycle ceiling may end a wait for the bus answer.
`timescale 1ns/1ps
module timer8_waveform_output_control_test
    import wave_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    bus_req_type bus_req;
    bus_rsp_type bus_rsp;
    compare_pins_type pins;
    logic irq;
    logic [1:0] level;
    logic [1:0] dir = 2'b11;
    logic [7:0] rd;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    int m, ch, act, top, c, p, w, hi, n, ca, cb;
    int cases[] = '{1, 2, 3, 11, 12, 13, 201, 213, 301, 302, 303, 312, 313,
        701, 702, 712, 713, 102, 103, 112, 113, 502, 512};
    always #4 mclk = ~mclk;
    wave_timer wave_timer_i (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req),
        .bus_rsp(bus_rsp), .pins(pins), .irq(irq));
    pin_load pin_load_i (.pins(pins), .dir(dir), .level(level));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Entered just after an edge; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
        bus_req.address <= a;
        bus_req.write <= wr;
        bus_req.read <= !wr;
        bus_req.writedata <= {24'h000000, d};
        @(posedge mclk);
        while (bus_rsp.waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
        rd = bus_rsp.readdata[7:0];
        bus_req.read <= 1'b0;
        bus_req.write <= 1'b0;
        @(posedge mclk);
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 90000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        bus_req = '0;
        bus_req.byteenable = 4'hF;
        void'($urandom(32'h0F536D88));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        bus(0, 8'hB0, 8'h00);
        check("ctrl reset", 8'h00, rd);
        bus(1, 8'hB0, 8'hFF);
        bus(0, 8'hB0, 8'h00);
        check("ctrl a", 8'hF3, rd);
        bus(1, 8'hB1, 8'hFF);
        bus(0, 8'hB1, 8'h00);
        check("ctrl b", 8'h08, rd);
        bus(0, 8'hB5, 8'h00);
        check("unmapped", 8'h00, rd);
        bus(1, 8'hB1, 8'h00);
        bus(1, 8'hB0, 8'h00);
        bus(1, 8'hB9, 8'h00);
        repeat (300) @(posedge mclk);
        check("irq masked", 1'b0, irq);
        bus(0, 8'hB8, 8'h00);
        check("status flags", 3'h7, rd[2:0]);
        bus(1, 8'hB9, 8'h01);
        check("irq on", 1'b1, irq);
        // Count moved off MAX, so no overflow refills the flag right away
        bus(1, 8'hB2, 8'h10);
        bus(1, 8'hB8, 8'h07);
        check("irq off", 1'b0, irq);
        bus(1, 8'hB0, 8'hF3);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        check("pins after reset", 2'b00, pins.en);
        bus(0, 8'hB0, 8'h00);
        check("ctrl after reset", 8'h00, rd);
        bus(0, 8'hB9, 8'h00);
        check("mask after reset", 8'h00, rd);
        $display("register test done");
        foreach (cases[i]) begin
            m = cases[i] / 100;
            ch = cases[i] / 10 % 10;
            act = cases[i] % 10;
            ca = 64 + $urandom % 187;
            cb = 1 + $urandom % (ca - 1);
            // Mode 0 first, so the compare writes land at once
            bus(1, 8'hB0, 8'h00);
            bus(1, 8'hB1, 8'h00);
            bus(1, 8'hB3, 8'(ca));
            bus(1, 8'hB4, 8'(cb));
            bus(1, 8'hB1, 8'(m / 4 * 8));
            bus(1, 8'hB0, 8'((ch ? act << 4 : act << 6) + m % 4));
            top = (m == 2 || m == 5 || m == 7) ? ca : 255;
            c = ch ? cb : ca;
            p = (m == 1 || m == 5) ? 2 * top : top + 1;
            w = (act == 1) ? 2 * p : p;
            if (act == 1) hi = (m == 1 || m == 3) ? 0 : p;
            else if (m == 3 || m == 7) hi = (c >= top) ? p : c + 1;
            else if (m == 1 || m == 5) hi = 2 * c;
            else hi = 0;
            if (act == 3) hi = p - hi;
            // Any full period gives the same count, whatever the latency
            repeat (2 * w + 300) @(posedge mclk);
            n = 0;
            repeat (w) begin
                @(negedge mclk);
                n += level[ch ? 0 : 1];
            end
            check("high cycles", hi, n);
            $display("case %0d done", cases[i]);
        end
        // Last case still drives B; without the direction bit the pin must stay low
        @(posedge mclk);
        dir <= 2'b00;
        n = 0;
        repeat (w) begin
            @(negedge mclk);
            n += level[0];
        end
        check("pin without direction", 0, n);
        $display("direction test done");
        close_out();
    end
endmodule // timer8_waveform_output_control_test
